/* src/cief_top.v */
// Contract
// - flags set on source events regardless of any enable (pin change flag here also needs its per_pin_change_mask bit)
// - control register fully readable and writable
// - bit 7 global enable gates every interrupt
// - bit 6 peripheral enable gates peripheral-register sources
// - bit 5 enables timer0 overflow interrupt
// - bit 4 enables external pin interrupt
// - bit 3 enables pin change; per-pin mask also required
// - bit 2 timer0 overflow flag, set on rollover, software clears
// - bit 1 external pin flag, set on valid edge, software clears
// - bit 0 pin change flag, set on enabled pin change, reset unknown
// - peripheral enable register holds eight read/write enables
// - peripheral bit 5 gates serial receive interrupt
// - peripheral bit 4 gates serial transmit interrupt
// - peripheral bit 3 gates synchronous serial interrupt
// - taking an interrupt flushes, clears global enable, pushes pc, vectors 0004h
// - return from interrupt pops address and sets global enable
// - external edge select: one rising, zero falling
// - event to vector latency is three instruction cycles
//
// Our own choices: the register offsets and the APB register port.
`include "cief_regs.vh"
module cief_top (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer0_rollover,
  input wire ext_irq_pin,
  input wire ext_edge_select,
  input wire [7:0] port_pins,
  input wire [7:0] per_pin_change_mask,
  input wire [7:0] peripheral_interrupt_request,
  input wire instr_cycle,
  input wire return_from_irq,
  input wire [12:0] core_pc,
  output reg irq_request,
  output reg flush_prefetch,
  output reg load_vector,
  output reg [12:0] next_pc_out
);
  reg [7:0] interrupt_control;
  reg [7:0] peripheral_interrupt_enable;
  reg ext_pin_q;
  reg [7:0] port_q;
  reg [1:0] lat_cnt;
  reg pending;
  wire [12:0] stack_top;
  wire wr_en;
  wire rd_en;
  wire ext_edge;
  wire pin_change;
  wire core_any;
  wire periph_any;
  wire req;
  wire take;
  wire byte0_wr;
  wire [7:0] ctl_wdata;
  localparam [7:0] CTL_RST = `CIEF_CONTROL_RST;
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign byte0_wr = wr_en & pstrb[0];
  // valid edge chosen by edge select
  assign ext_edge = ext_edge_select ? (ext_irq_pin & ~ext_pin_q) : (~ext_irq_pin & ext_pin_q);
  assign pin_change = |((port_pins ^ port_q) & per_pin_change_mask);
  assign core_any = (interrupt_control[`CIEF_T0IE_BIT] & interrupt_control[`CIEF_T0IF_BIT])
    | (interrupt_control[`CIEF_EXTIE_BIT] & interrupt_control[`CIEF_EXTIF_BIT])
    | (interrupt_control[`CIEF_PCIE_BIT] & interrupt_control[`CIEF_PCIF_BIT]);
  // all eight enable/flag pairs, including serial rx/tx and sync serial
  assign periph_any = interrupt_control[`CIEF_PERIPH_IRQ_EN_BIT]
    & |(peripheral_interrupt_enable & peripheral_interrupt_request);
  assign req = interrupt_control[`CIEF_GLOBAL_EN_BIT] & (core_any | periph_any);
  assign take = pending & instr_cycle & (lat_cnt == `CIEF_LATENCY_CYC - 2'h1);
  assign ctl_wdata = pwdata[7:0];
  cief_stack u_stack (
    .ref_clk(ref_clk),
    .reset(reset),
    .push(take),
    .pop(return_from_irq & instr_cycle & ~take),
    .push_data(core_pc),
    .top_data(stack_top)
  );
  // control register: hardware set wins over a software clear in the same cycle
  always @(posedge ref_clk) begin
    if (reset) begin
      interrupt_control[7:1] <= CTL_RST[7:1];
    end else begin
      if (byte0_wr && paddr == `CIEF_OFF_CONTROL) begin
        interrupt_control[7:1] <= ctl_wdata[7:1];
      end
      if (take) begin
        interrupt_control[`CIEF_GLOBAL_EN_BIT] <= 1'b0;
      end else if (return_from_irq && instr_cycle) begin
        interrupt_control[`CIEF_GLOBAL_EN_BIT] <= 1'b1;
      end
      if (timer0_rollover) begin
        interrupt_control[`CIEF_T0IF_BIT] <= 1'b1;
      end
      if (ext_edge) begin
        interrupt_control[`CIEF_EXTIF_BIT] <= 1'b1;
      end
    end
  end
  // pin change flag keeps no reset value, as it powers up unknown
  always @(posedge ref_clk) begin
    if (pin_change) begin
      interrupt_control[`CIEF_PCIF_BIT] <= 1'b1;
    end else if (byte0_wr && paddr == `CIEF_OFF_CONTROL) begin
      interrupt_control[`CIEF_PCIF_BIT] <= ctl_wdata[`CIEF_PCIF_BIT];
    end
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      peripheral_interrupt_enable <= `CIEF_PERIPH_EN_RST;
      ext_pin_q <= 1'b0;
      port_q <= 8'h00;
    end else begin
      if (byte0_wr && paddr == `CIEF_OFF_PERIPH_EN) begin
        peripheral_interrupt_enable <= ctl_wdata;
      end
      ext_pin_q <= ext_irq_pin;
      port_q <= port_pins;
    end
  end
  // latency: request seen, vector loaded after three instruction cycles
  always @(posedge ref_clk) begin
    if (reset) begin
      pending <= 1'b0;
      lat_cnt <= 2'h0;
      irq_request <= 1'b0;
      flush_prefetch <= 1'b0;
      load_vector <= 1'b0;
      next_pc_out <= 13'h0000;
    end else begin
      irq_request <= req;
      flush_prefetch <= 1'b0;
      load_vector <= 1'b0;
      if (take) begin
        pending <= 1'b0;
        lat_cnt <= 2'h0;
        flush_prefetch <= 1'b1;
        load_vector <= 1'b1;
        next_pc_out <= `CIEF_VECTOR;
      end else if (return_from_irq && instr_cycle) begin
        load_vector <= 1'b1;
        next_pc_out <= stack_top;
      end else if (!pending && req) begin
        pending <= 1'b1;
        lat_cnt <= 2'h0;
      end else if (pending && instr_cycle) begin
        lat_cnt <= lat_cnt + 2'h1;
      end
    end
  end
  // apb: one wait state, zero-wait would need combinational prdata
  always @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (rd_en) begin
        case (paddr)
          `CIEF_OFF_CONTROL: prdata <= {24'h000000, interrupt_control};
          `CIEF_OFF_PERIPH_EN: prdata <= {24'h000000, peripheral_interrupt_enable};
          `CIEF_OFF_PERIPH_REQ: prdata <= {24'h000000, peripheral_interrupt_request};
          `CIEF_OFF_STATUS: prdata <= {29'h00000000, pending, req, core_any};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end else if (wr_en) begin
        case (paddr)
          `CIEF_OFF_CONTROL, `CIEF_OFF_PERIPH_EN: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // cief_top

/* src/cief_regs.vh */
`ifndef CIEF_REGS_VH
`define CIEF_REGS_VH
// apb byte offsets
`define CIEF_OFF_CONTROL 12'h000
`define CIEF_OFF_PERIPH_EN 12'h004
`define CIEF_OFF_PERIPH_REQ 12'h008
`define CIEF_OFF_STATUS 12'h00c
// control register field positions
`define CIEF_GLOBAL_EN_BIT 7
`define CIEF_PERIPH_IRQ_EN_BIT 6
`define CIEF_T0IE_BIT 5
`define CIEF_EXTIE_BIT 4
`define CIEF_PCIE_BIT 3
`define CIEF_T0IF_BIT 2
`define CIEF_EXTIF_BIT 1
`define CIEF_PCIF_BIT 0
// peripheral enable field positions
`define CIEF_SRX_BIT 5
`define CIEF_STX_BIT 4
`define CIEF_SYNC_SERIAL_BIT 3
// reset values
`define CIEF_CONTROL_RST 8'h00
`define CIEF_PERIPH_EN_RST 8'h00
// core vector and latency
`define CIEF_VECTOR 13'h0004
`define CIEF_LATENCY_CYC 2'h3
`endif

/* src/cief_stack.v */
// 8-level return address stack; read data registered
module cief_stack (
  input wire ref_clk,
  input wire reset,
  input wire push,
  input wire pop,
  input wire [12:0] push_data,
  output reg [12:0] top_data
);
  reg [12:0] mem [0:7];
  reg [2:0] ptr;
  wire [2:0] ptr_dec;
  wire [2:0] ptr_dec2;
  assign ptr_dec = ptr - 3'h1;
  // after a pop the top shows the entry beneath the one popped
  assign ptr_dec2 = ptr - 3'h2;
  always @(posedge ref_clk) begin
    if (reset) begin
      ptr <= 3'h0;
      top_data <= 13'h0000;
    end else if (push) begin
      mem[ptr] <= push_data;
      ptr <= ptr + 3'h1;
      top_data <= push_data;
    end else if (pop) begin
      ptr <= ptr_dec;
      top_data <= mem[ptr_dec2];
    end
  end
endmodule // cief_stack

/* sim/cief_top_properties.sv */
module cief_top_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_request,
  input wire logic flush_prefetch,
  input wire logic load_vector,
  input wire logic [12:0] next_pc_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pready && paddr > 12'h00c |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("error data");
  property p_rst; $fell(reset) |-> !irq_request && !load_vector; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_vec; flush_prefetch |-> load_vector && next_pc_out == 13'h0004; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_req; flush_prefetch |-> $past(irq_request); endproperty
  a_req: assert property (p_req) else $error("take without request");
  // the take drops the global enable, so the request must fall soon after
  property p_gie; flush_prefetch |-> ##[1:3] !irq_request; endproperty
  a_gie: assert property (p_gie) else $error("request stays");
endmodule // cief_top_chk

bind cief_top cief_top_chk cief_top_chk_i (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .irq_request, .flush_prefetch, .load_vector, .next_pc_out);

/* sim/cief_core_model.sv */
module cief_core_model (
  input wire logic ref_clk,
  input wire logic run,
  output logic instr_cycle,
  output logic [12:0] core_pc
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'h0;
  // one instruction cycle every four clocks; latency counts these
  assign instr_cycle = run && phase == 2'h3;
  initial core_pc = 13'h0100;
  always @(posedge ref_clk) begin
    phase <= run ? phase + 2'h1 : 2'h0;
    if (instr_cycle) core_pc <= core_pc + 13'h1;
  end
endmodule // cief_core_model

/* sim/cief_top_tb_top.sv */
module cief_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, run = 1'h0;
  logic timer0_rollover = 1'h0, ext_irq_pin = 1'h0, ext_edge_select = 1'h1, return_from_irq = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] port_pins = 8'h0, per_pin_change_mask = 8'h04, peripheral_interrupt_request = 8'h0;
  logic [12:0] core_pc, next_pc_out, ret_pc;
  logic pready, pslverr, instr_cycle, irq_request, flush_prefetch, load_vector, err;
  int miscompares = 0, checked = 0, cycles = 0;
  cief_top cief_top_i (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'h1), .prdata, .pready, .pslverr, .timer0_rollover, .ext_irq_pin, .ext_edge_select,
    .port_pins, .per_pin_change_mask, .peripheral_interrupt_request, .instr_cycle,
    .return_from_irq, .core_pc, .irq_request, .flush_prefetch, .load_vector, .next_pc_out);
  cief_core_model cief_core_model_i (.ref_clk, .run, .instr_cycle, .core_pc);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic t_regs;
    apb(1'h0, 12'h004, 8'h0); chk("pie", rd, 32'h0);
    apb(1'h0, 12'h000, 8'h0); chk("ctl", rd[7:1], 32'h0);
    apb(1'h1, 12'h004, 8'ha5); apb(1'h0, 12'h004, 8'h0); chk("pie rw", rd, 32'ha5);
    apb(1'h1, 12'h000, 8'h7a); apb(1'h0, 12'h000, 8'h0); chk("ctl rw", rd, 32'h7a);
    chk("gie off", irq_request, 1'h0);
    apb(1'h1, 12'h000, 8'h00);
    apb(1'h0, 12'h010, 8'h0); chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'h1, 12'h008, 8'hff); chk("ro write", err, 1'h1);
  endtask
  task automatic t_flags;
    timer0_rollover <= 1'h1;
    ext_irq_pin <= 1'h1;
    port_pins <= 8'h04;
    @(posedge ref_clk);
    timer0_rollover <= 1'h0;
    repeat (2) @(posedge ref_clk);
    apb(1'h0, 12'h000, 8'h0); chk("flags", rd, 32'h07);
    apb(1'h1, 12'h000, 8'h00);
    ext_irq_pin <= 1'h0;
    repeat (2) @(posedge ref_clk);
    apb(1'h0, 12'h000, 8'h0); chk("wrong edge", rd, 32'h0);
    ext_edge_select <= 1'h0;
    ext_irq_pin <= 1'h1;
    repeat (2) @(posedge ref_clk);
    apb(1'h0, 12'h000, 8'h0); chk("rise ignored", rd, 32'h0);
    ext_irq_pin <= 1'h0;
    repeat (2) @(posedge ref_clk);
    apb(1'h0, 12'h000, 8'h0); chk("fall edge", rd, 32'h02);
    apb(1'h1, 12'h000, 8'h00);
    ext_edge_select <= 1'h1;
  endtask
  task automatic t_take;
    // flags were cleared above before this enable
    // timer0 stimulus stays idle after its flag is cleared
    apb(1'h1, 12'h000, 8'ha0); chk("idle", irq_request, 1'h0);
    timer0_rollover <= 1'h1;
    @(posedge ref_clk);
    timer0_rollover <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk("req", irq_request, 1'h1);
    run <= 1'h1;
    repeat (40) if (load_vector !== 1'h1) @(posedge ref_clk);
    chk("vector", next_pc_out, 13'h0004);
    ret_pc = core_pc - 13'h1;
    apb(1'h0, 12'h000, 8'h0); chk("taken", rd, 32'h24);
    apb(1'h1, 12'h000, 8'h20);
    return_from_irq <= 1'h1;
    @(posedge ref_clk);
    repeat (8) if (instr_cycle !== 1'h1) @(posedge ref_clk);
    return_from_irq <= 1'h0;
    @(posedge ref_clk);
    repeat (8) if (load_vector !== 1'h1) @(posedge ref_clk);
    chk("return", next_pc_out, ret_pc);
    run <= 1'h0;
    apb(1'h0, 12'h000, 8'h0); chk("gie back", rd, 32'ha0);
  endtask
  task automatic t_periph;
    for (int b = 3; b < 6; b++) begin
      peripheral_interrupt_request <= 8'h1 << b;
      apb(1'h1, 12'h004, 8'h1 << b);
      apb(1'h1, 12'h000, 8'h80); chk("peripheral_irq_enable off", irq_request, 1'h0);
      apb(1'h1, 12'h000, 8'hc0); chk("peripheral_irq_enable on", irq_request, 1'h1);
      apb(1'h1, 12'h000, 8'h00);
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    t_regs;
    t_flags;
    t_take;
    t_periph;
    give_verdict;
  end
endmodule // cief_top_tb_top
